// *** rtl/msdc_regs.vh ***
// Register map, field layout and constants for the MAC speed/duplex block
// Function
// - Duplex bit writable when auto duplex off
// - Duplex 0 is half, 1 is full
// - Auto duplex on: bit reads detected duplex
// - Never half duplex at 1000 Mbps
// - Speed 0=10M, 1=100M, 2/3=1000M
// - Speed field writable when auto speed off
// - Auto speed on: field reads detected speed
// - Reset protection keeps duplex and speed
// - Power-up values from EEPROM, else OTP
// - No configuration source: duplex and speed fields default 0
// - USB/lite reset reloads last image or the fallbacks
// - Auto duplex default from flag, fallback 1
// - Auto speed default from flag, fallback 0
`ifndef MSDC_REGS_VH
`define MSDC_REGS_VH

// Register byte offsets
`define MSDC_OFF_MAC_CTRL   12'h100
`define MSDC_OFF_AUTO_CTRL  12'h110
`define MSDC_OFF_STATUS     12'h114
`define MSDC_ADDR_W         12

// mac_control fields
`define MSDC_CTRL_RST_BIT   0
`define MSDC_CTRL_SPD_LO    1
`define MSDC_CTRL_SPD_HI    2
`define MSDC_CTRL_DUP_BIT   3

// auto_control fields
`define MSDC_AUTO_DUP_BIT   0
`define MSDC_AUTO_SPD_BIT   1
`define MSDC_AUTO_PROT_BIT  2

// status fields
`define MSDC_STAT_DUP_BIT   0
`define MSDC_STAT_SPD_LO    1
`define MSDC_STAT_SPD_HI    2
`define MSDC_STAT_IMG_BIT   3
`define MSDC_STAT_RST_BIT   4

// Encodings and fallback values
`define MSDC_DUP_HALF       1'b0
`define MSDC_DUP_FULL       1'b1
`define MSDC_SPD_10         2'h0
`define MSDC_SPD_100        2'h1
`define MSDC_SPD_DEF        2'h0
`define MSDC_DUP_DEF        1'b0
`define MSDC_ADD_DEF        1'b1
`define MSDC_ASPD_DEF       1'b0

// MAC soft reset hold count; the reset stays set for one clock cycle more than this
`define MSDC_HOLD_CYC       5'h10
`define MSDC_HOLD_W         5

// AXI responses
`define MSDC_RESP_OKAY      2'h0
`define MSDC_RESP_SLVERR    2'h2

`endif

// *** rtl/msdc_sync3.v ***
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module msdc_sync3 #(
  parameter WIDTH = 3
) (
  input  wire             aclk,     // System clock
  input  wire             aresetn,  // Synchronous reset, active low
  input  wire [WIDTH-1:0] async_in, // Input from another domain
  output reg  [WIDTH-1:0] sync_out  // Filtered, synchronised value
);

  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  wire [WIDTH-1:0] agree;

  // A bit moves only where stages two and three match
  assign agree = ~(s2_reg ^ s3_reg);

  // Stage one feeds stage two only, never any gate
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg   <= {WIDTH{1'b0}};
      s2_reg   <= {WIDTH{1'b0}};
      s3_reg   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      s1_reg   <= async_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      sync_out <= (s2_reg & agree) | (sync_out & ~agree);
    end
  end

endmodule

// *** rtl/msdc_cfg_pick.v ***
// Chooses the configuration image: EEPROM first, OTP second, fixed values last
`timescale 1ns/1ps
`include "msdc_regs.vh"
module msdc_cfg_pick (
  input  wire       ee_present,  // EEPROM image available
  input  wire       otp_valid,   // OTP has been programmed
  input  wire       ee_dup,      // EEPROM duplex value
  input  wire [1:0] ee_spd,      // EEPROM speed value
  input  wire       ee_add,      // EEPROM auto duplex flag
  input  wire       ee_aspd,     // EEPROM auto speed flag
  input  wire       otp_dup,     // OTP duplex value
  input  wire [1:0] otp_spd,     // OTP speed value
  input  wire       otp_add,     // OTP auto duplex flag
  input  wire       otp_aspd,    // OTP auto speed flag
  output reg        pick_dup,    // Chosen duplex
  output reg  [1:0] pick_spd,    // Chosen speed
  output reg        pick_add,    // Chosen auto duplex flag
  output reg        pick_aspd,   // Chosen auto speed flag
  output wire       pick_valid   // Some image exists
);

  assign pick_valid = ee_present | otp_valid;

  // Source priority, fixed fallbacks when neither memory is usable
  always @* begin
    if (ee_present) begin
      pick_dup  = ee_dup;
      pick_spd  = ee_spd;
      pick_add  = ee_add;
      pick_aspd = ee_aspd;
    end else if (otp_valid) begin
      pick_dup  = otp_dup;
      pick_spd  = otp_spd;
      pick_add  = otp_add;
      pick_aspd = otp_aspd;
    end else begin
      pick_dup  = `MSDC_DUP_DEF;
      pick_spd  = `MSDC_SPD_DEF;
      pick_add  = `MSDC_ADD_DEF;
      pick_aspd = `MSDC_ASPD_DEF;
    end
  end

endmodule

// *** rtl/msdc_top.v ***
// MAC duplex, speed and soft-reset configuration with an AXI4-Lite slave
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "msdc_regs.vh"
module msdc_top (
  input  wire        aclk,             // System clock, 250 MHz
  input  wire        aresetn,          // Synchronous reset, active low
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,     // Write address
  input  wire        s_axi_awvalid,    // Write address valid
  output reg         s_axi_awready,    // Write address ready
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,      // Write data
  input  wire [3:0]  s_axi_wstrb,      // Write byte strobes
  input  wire        s_axi_wvalid,     // Write data valid
  output reg         s_axi_wready,     // Write data ready
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,      // Write response
  output reg         s_axi_bvalid,     // Write response valid
  input  wire        s_axi_bready,     // Write response ready
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,     // Read address
  input  wire        s_axi_arvalid,    // Read address valid
  output reg         s_axi_arready,    // Read address ready
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,      // Read data
  output reg  [1:0]  s_axi_rresp,      // Read response
  output reg         s_axi_rvalid,     // Read data valid
  input  wire        s_axi_rready,     // Read data ready
  // Reset events and configuration image
  input  wire        usb_reset,        // USB reset event, one cycle
  input  wire        soft_lite_reset,  // Soft lite reset event, one cycle
  input  wire        cfg_load,         // Configuration image loaded, one cycle
  input  wire        cfg_ee_present,   // EEPROM image present
  input  wire        cfg_otp_valid,    // OTP programmed
  input  wire        cfg_ee_dup,       // EEPROM duplex value
  input  wire [1:0]  cfg_ee_spd,       // EEPROM speed value
  input  wire        cfg_ee_add,       // EEPROM flag_auto_duplex
  input  wire        cfg_ee_aspd,      // EEPROM flag_auto_speed
  input  wire        cfg_otp_dup,      // OTP duplex value
  input  wire [1:0]  cfg_otp_spd,      // OTP speed value
  input  wire        cfg_otp_add,      // OTP flag_auto_duplex
  input  wire        cfg_otp_aspd,     // OTP flag_auto_speed
  // Link results from the PHY side
  input  wire        det_duplex,       // Detected duplex, 1 is full
  input  wire [1:0]  det_speed,        // Detected speed code
  // MAC operating controls
  output reg         mac_full_duplex,  // MAC runs full duplex
  output reg  [1:0]  mac_speed,        // MAC speed code
  output reg         mac_in_reset      // MAC held in soft reset
);

  // Configuration fields
  reg        duplex_select_reg;
  reg        duplex_select_next;
  reg  [1:0] speed_select_reg;
  reg  [1:0] speed_select_next;
  reg        auto_duplex_reg;
  reg        auto_duplex_next;
  reg        auto_speed_detect_reg;
  reg        auto_speed_detect_next;
  reg        rst_protect_reg;
  reg        rst_protect_next;
  // Last loaded configuration image
  reg        img_valid_reg;
  reg        img_dup_reg;
  reg  [1:0] img_spd_reg;
  reg        img_add_reg;
  reg        img_aspd_reg;
  // Self-clearing MAC reset
  reg        mac_soft_reset_reg;
  reg        mac_soft_reset_next;
  reg  [`MSDC_HOLD_W-1:0] hold_cnt_reg;
  reg  [`MSDC_HOLD_W-1:0] hold_cnt_next;
  // AXI state
  reg        aw_held_reg;
  reg [11:0] aw_addr_reg;
  reg        w_held_reg;
  reg [31:0] w_data_reg;
  reg  [3:0] w_strb_reg;
  reg [31:0] rd_word;
  reg        rd_hit;

  wire        sync_dup;
  wire  [1:0] sync_spd;
  wire        pick_dup;
  wire  [1:0] pick_spd;
  wire        pick_add;
  wire        pick_aspd;
  wire        pick_valid;
  wire        any_reset;
  wire        wr_fire;
  wire        wr_ctrl;
  wire        wr_auto;
  wire        wr_hit;
  wire        ar_fire;
  wire        spd_gig;
  wire        eff_full;

  // Link results come from the PHY domain
  msdc_sync3 #(
    .WIDTH (3)
  ) u_det_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({det_speed, det_duplex}),
    .sync_out ({sync_spd, sync_dup})
  );

  // Image choice for a fresh load
  msdc_cfg_pick u_pick (
    .ee_present (cfg_ee_present),
    .otp_valid  (cfg_otp_valid),
    .ee_dup     (cfg_ee_dup),
    .ee_spd     (cfg_ee_spd),
    .ee_add     (cfg_ee_add),
    .ee_aspd    (cfg_ee_aspd),
    .otp_dup    (cfg_otp_dup),
    .otp_spd    (cfg_otp_spd),
    .otp_add    (cfg_otp_add),
    .otp_aspd   (cfg_otp_aspd),
    .pick_dup   (pick_dup),
    .pick_spd   (pick_spd),
    .pick_add   (pick_add),
    .pick_aspd  (pick_aspd),
    .pick_valid (pick_valid)
  );

  assign any_reset = usb_reset | soft_lite_reset;
  assign wr_fire   = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_ctrl   = wr_fire & (aw_addr_reg == `MSDC_OFF_MAC_CTRL) & w_strb_reg[0];
  assign wr_auto   = wr_fire & (aw_addr_reg == `MSDC_OFF_AUTO_CTRL) & w_strb_reg[0];
  assign wr_hit    = (aw_addr_reg == `MSDC_OFF_MAC_CTRL) | (aw_addr_reg == `MSDC_OFF_AUTO_CTRL) |
                     (aw_addr_reg == `MSDC_OFF_STATUS);
  assign ar_fire   = s_axi_arvalid & s_axi_arready;

  // Codes 2 and 3 both mean 1000 Mbps, so the high bit alone marks it
  assign spd_gig  = speed_select_reg[1];
  assign eff_full = spd_gig ? `MSDC_DUP_FULL : duplex_select_reg;

  // Image capture: remembers what the loader last produced
  always @(posedge aclk) begin
    if (!aresetn) begin
      img_valid_reg <= 1'b0;
      img_dup_reg   <= `MSDC_DUP_DEF;
      img_spd_reg   <= `MSDC_SPD_DEF;
      img_add_reg   <= `MSDC_ADD_DEF;
      img_aspd_reg  <= `MSDC_ASPD_DEF;
    end else if (cfg_load) begin
      img_valid_reg <= pick_valid;
      img_dup_reg   <= pick_dup;
      img_spd_reg   <= pick_spd;
      img_add_reg   <= pick_add;
      img_aspd_reg  <= pick_aspd;
    end
  end

  // Field update; resets win over loads, loads over software, tracking over software writes
  always @* begin
    duplex_select_next     = duplex_select_reg;
    speed_select_next      = speed_select_reg;
    auto_duplex_next       = auto_duplex_reg;
    auto_speed_detect_next = auto_speed_detect_reg;
    rst_protect_next       = rst_protect_reg;
    if (any_reset) begin
      // Image values are the fallbacks when nothing was ever loaded
      auto_duplex_next       = img_add_reg;
      auto_speed_detect_next = img_aspd_reg;
      if (!rst_protect_reg) begin
        duplex_select_next = img_dup_reg;
        speed_select_next  = img_spd_reg;
      end
    end else if (cfg_load) begin
      duplex_select_next     = pick_dup;
      speed_select_next      = pick_spd;
      auto_duplex_next       = pick_add;
      auto_speed_detect_next = pick_aspd;
    end else begin
      if (wr_auto) begin
        auto_duplex_next       = w_data_reg[`MSDC_AUTO_DUP_BIT];
        auto_speed_detect_next = w_data_reg[`MSDC_AUTO_SPD_BIT];
        rst_protect_next       = w_data_reg[`MSDC_AUTO_PROT_BIT];
      end
      // Under auto detection the field follows the link and ignores writes
      if (auto_duplex_reg)
        duplex_select_next = sync_dup;
      else if (wr_ctrl)
        duplex_select_next = w_data_reg[`MSDC_CTRL_DUP_BIT];
      if (auto_speed_detect_reg)
        speed_select_next = sync_spd;
      else if (wr_ctrl)
        speed_select_next = w_data_reg[`MSDC_CTRL_SPD_HI:`MSDC_CTRL_SPD_LO];
    end
  end

  // Self-clearing reset: a write of 1 restarts the hold count
  always @* begin
    mac_soft_reset_next = mac_soft_reset_reg;
    hold_cnt_next       = hold_cnt_reg;
    if (wr_ctrl && w_data_reg[`MSDC_CTRL_RST_BIT]) begin
      mac_soft_reset_next = 1'b1;
      hold_cnt_next       = `MSDC_HOLD_CYC;
    end else if (mac_soft_reset_reg) begin
      if (hold_cnt_reg == {`MSDC_HOLD_W{1'b0}})
        mac_soft_reset_next = 1'b0;
      else
        hold_cnt_next = hold_cnt_reg - {{(`MSDC_HOLD_W-1){1'b0}}, 1'b1};
    end
  end

  // Configuration and MAC control registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      duplex_select_reg     <= `MSDC_DUP_DEF;
      speed_select_reg      <= `MSDC_SPD_DEF;
      auto_duplex_reg       <= `MSDC_ADD_DEF;
      auto_speed_detect_reg <= `MSDC_ASPD_DEF;
      rst_protect_reg       <= 1'b0;
      mac_soft_reset_reg    <= 1'b0;
      hold_cnt_reg          <= {`MSDC_HOLD_W{1'b0}};
    end else begin
      duplex_select_reg     <= duplex_select_next;
      speed_select_reg      <= speed_select_next;
      auto_duplex_reg       <= auto_duplex_next;
      auto_speed_detect_reg <= auto_speed_detect_next;
      rst_protect_reg       <= rst_protect_next;
      mac_soft_reset_reg    <= mac_soft_reset_next;
      hold_cnt_reg          <= hold_cnt_next;
    end
  end

  // MAC facing outputs, one register stage after the fields
  always @(posedge aclk) begin
    if (!aresetn) begin
      mac_full_duplex <= `MSDC_DUP_HALF;
      mac_speed       <= `MSDC_SPD_10;
      mac_in_reset    <= 1'b0;
    end else begin
      mac_full_duplex <= eff_full;
      mac_speed       <= speed_select_reg;
      mac_in_reset    <= mac_soft_reset_reg;
    end
  end

  // Write channel: address and data are taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= {`MSDC_ADDR_W{1'b0}};
      w_held_reg    <= 1'b0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MSDC_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      // The response goes out once both halves are in hand
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `MSDC_RESP_OKAY : `MSDC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode; reserved bits read zero, the status word reads back live state
  always @* begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case ({s_axi_araddr[11:2], 2'h0})
      `MSDC_OFF_MAC_CTRL: begin
        rd_word[`MSDC_CTRL_DUP_BIT]                  = duplex_select_reg;
        rd_word[`MSDC_CTRL_SPD_HI:`MSDC_CTRL_SPD_LO] = speed_select_reg;
        rd_word[`MSDC_CTRL_RST_BIT]                  = mac_soft_reset_reg;
      end
      `MSDC_OFF_AUTO_CTRL: begin
        rd_word[`MSDC_AUTO_DUP_BIT]  = auto_duplex_reg;
        rd_word[`MSDC_AUTO_SPD_BIT]  = auto_speed_detect_reg;
        rd_word[`MSDC_AUTO_PROT_BIT] = rst_protect_reg;
      end
      `MSDC_OFF_STATUS: begin
        rd_word[`MSDC_STAT_DUP_BIT]                  = eff_full;
        rd_word[`MSDC_STAT_SPD_HI:`MSDC_STAT_SPD_LO] = speed_select_reg;
        rd_word[`MSDC_STAT_IMG_BIT]                  = img_valid_reg;
        rd_word[`MSDC_STAT_RST_BIT]                  = mac_soft_reset_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel: one outstanding read, data held until taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `MSDC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_fire;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `MSDC_RESP_OKAY : `MSDC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// *** dv/msdc_checker.sv ***
// Concurrent checks on the ports of the MAC speed/duplex block
`timescale 1ns/1ps
module msdc_checker (
  input wire        aclk,            // Clock
  input wire        aresetn,         // Sync reset, low
  input wire        s_axi_awready,   // Write addr ready
  input wire [11:0] s_axi_araddr,    // Read address
  input wire        s_axi_arvalid,   // Read addr valid
  input wire        s_axi_arready,   // Read addr ready
  input wire        s_axi_bvalid,    // Write resp valid
  input wire        s_axi_bready,    // Write resp ready
  input wire [1:0]  s_axi_bresp,     // Write response
  input wire        s_axi_rvalid,    // Read data valid
  input wire        s_axi_rready,    // Read data ready
  input wire [31:0] s_axi_rdata,     // Read data
  input wire [1:0]  s_axi_rresp,     // Read response
  input wire        usb_reset,       // USB reset pulse
  input wire        soft_lite_reset, // Lite reset pulse
  input wire        cfg_load,        // Image load pulse
  input wire        cfg_ee_present,  // EEPROM present
  input wire [1:0]  cfg_ee_spd,      // EEPROM speed
  input wire        cfg_ee_aspd,     // EEPROM auto speed
  input wire        mac_full_duplex, // Effective duplex
  input wire [1:0]  mac_speed,       // Effective speed
  input wire        mac_in_reset     // MAC soft reset
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  gig_full_a: assert property (mac_speed[1] |-> mac_full_duplex)
    else $error("half duplex at gigabit speed");
  rst_hold_a: assert property ($rose(mac_in_reset) |-> mac_in_reset [*8])
    else $error("MAC reset dropped too early");
  rst_clear_a: assert property ($rose(mac_in_reset) |-> ##[8:40] !mac_in_reset)
    else $error("MAC reset did not clear itself");
  // Image speed reaches the MAC two edges after the load pulse
  cfg_ee_a: assert property (cfg_load && cfg_ee_present && !cfg_ee_aspd && !usb_reset && !soft_lite_reset
    |=> ##1 mac_speed == $past(cfg_ee_spd, 2))
    else $error("EEPROM speed not applied");
  unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h104
    |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
endmodule

// *** dv/msdc_top_tb.sv ***
// Self-checking bench for the MAC speed/duplex block
`timescale 1ns/1ps
module msdc_top_tb;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg         usb_rst, lite_rst, cfg_load, ee_p, otp_v, ee_dup, ee_add, ee_aspd;
  reg         otp_dup, otp_add, otp_aspd, det_dup;
  reg  [1:0]  ee_spd, otp_spd, det_spd;
  reg  [11:0] awaddr, araddr;
  reg  [31:0] wdata, rnd;
  wire        awready, wready, bvalid, arready, rvalid, fdx, mac_rst;
  wire [1:0]  bresp, rresp, mspd;
  wire [31:0] rdata;
  reg  [33:0] exq[$];
  reg  [33:0] e;
  integer     mismatches, cmp_count, i;

  msdc_top DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .usb_reset(usb_rst), .soft_lite_reset(lite_rst), .cfg_load(cfg_load),
    .cfg_ee_present(ee_p), .cfg_otp_valid(otp_v), .cfg_ee_dup(ee_dup), .cfg_ee_spd(ee_spd),
    .cfg_ee_add(ee_add), .cfg_ee_aspd(ee_aspd), .cfg_otp_dup(otp_dup), .cfg_otp_spd(otp_spd),
    .cfg_otp_add(otp_add), .cfg_otp_aspd(otp_aspd), .det_duplex(det_dup), .det_speed(det_spd),
    .mac_full_duplex(fdx), .mac_speed(mspd), .mac_in_reset(mac_rst)
  );

  // 250 MHz clock
  always #2 aclk = ~aclk;

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task check(input [33:0] seen, input [33:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task conclude;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // Each channel is released at the edge its ready is seen; bready rises one edge before bvalid
  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // Loop ends at the edge where the later of the two halves is taken
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      check({32'h0, bresp}, {32'h0, er});
      bready <= 1'b0;
    end
  endtask

  // Notes the expected word; the monitor compares it when it arrives
  task rd(input [11:0] a, input [31:0] d, input [1:0] er);
    begin
      exq.push_back({er, d});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
    end
  endtask

  // One-cycle event pulse: bit2 load, bit1 lite reset, bit0 USB reset
  task pulse(input [2:0] k);
    begin
      @(posedge aclk);
      {cfg_load, lite_rst, usb_rst} <= k;
      @(posedge aclk);
      {cfg_load, lite_rst, usb_rst} <= 3'h0;
    end
  endtask

  // Read monitor takes the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      e = exq.pop_front();
      check({rresp, rdata}, e);
    end
  end

  // Watchdog; the whole run needs a few hundred cycles
  initial begin
    #100000;
    mismatches = mismatches + 1;
    conclude;
  end

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
    {usb_rst, lite_rst, cfg_load, ee_p, otp_v, ee_dup, ee_add, ee_aspd} = 0;
    {otp_dup, otp_add, otp_aspd, det_dup, ee_spd, otp_spd, det_spd} = 0;
    mismatches = 0;
    cmp_count = 0;
    rnd = 32'h08B1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h110, 32'h1, 2'h0);
    rd(12'h100, 32'h0, 2'h0);
    $display("Test fallback done");
    // Manual mode over every speed code and duplex value; the MAC soft reset bit is written 0 here
    wr(12'h110, 32'h0, 2'h0);
    for (i = 0; i < 8; i = i + 1) begin
      wr(12'h100, {28'h0, i[2:0], 1'b0}, 2'h0);
      rd(12'h100, {28'h0, i[2:0], 1'b0}, 2'h0);
      rd(12'h114, {29'h0, i[1:0], i[2] | i[1]}, 2'h0);
      check({31'h0, fdx, mspd}, {31'h0, i[2] | i[1], i[1:0]});
    end
    $display("Test manual done");
    // Auto mode: random link results, inverse writes must be ignored
    wr(12'h110, 32'h3, 2'h0);
    for (i = 0; i < 4; i = i + 1) begin
      rnd = lfsr(rnd);
      @(posedge aclk);
      det_dup <= rnd[0];
      det_spd <= rnd[2:1];
      repeat (8) @(posedge aclk);
      wr(12'h100, {28'h0, ~rnd[0], ~rnd[2:1], 1'b0}, 2'h0);
      rd(12'h100, {28'h0, rnd[0], rnd[2:1], 1'b0}, 2'h0);
    end
    $display("Test auto done");
    // Self-clearing MAC reset
    wr(12'h100, 32'h1, 2'h0);
    repeat (2) @(posedge aclk);
    check({33'h0, mac_rst}, 34'h1);
    repeat (24) @(posedge aclk);
    check({33'h0, mac_rst}, 34'h0);
    rd(12'h100, {28'h0, rnd[0], rnd[2:1], 1'b0}, 2'h0);
    $display("Test soft reset done");
    // Image sources, reloads and protection
    @(posedge aclk);
    {ee_p, ee_dup, ee_spd, otp_v, otp_spd} <= 7'h6E;
    pulse(3'h4);
    rd(12'h100, 32'hA, 2'h0);
    rd(12'h110, 32'h0, 2'h0);
    rd(12'h114, 32'hB, 2'h0);
    @(posedge aclk);
    ee_p <= 1'b0;
    det_dup <= 1'b0;
    pulse(3'h4);
    rd(12'h100, 32'h4, 2'h0);
    wr(12'h100, 32'h0, 2'h0);
    pulse(3'h1);
    rd(12'h100, 32'h4, 2'h0);
    wr(12'h110, 32'h4, 2'h0);
    wr(12'h100, 32'h2, 2'h0);
    pulse(3'h2);
    rd(12'h100, 32'h2, 2'h0);
    wr(12'h110, 32'h0, 2'h0);
    @(posedge aclk);
    otp_v <= 1'b0;
    pulse(3'h4);
    rd(12'h100, 32'h0, 2'h0);
    rd(12'h110, 32'h1, 2'h0);
    rd(12'h114, 32'h0, 2'h0);
    $display("Test image done");
    // Unmapped place is refused
    rd(12'h104, 32'h0, 2'h2);
    wr(12'h104, 32'hF, 2'h2);
    $display("Test unmapped done");
    conclude;
  end
endmodule

bind msdc_top msdc_checker chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .usb_reset(usb_reset), .soft_lite_reset(soft_lite_reset), .cfg_load(cfg_load),
  .cfg_ee_present(cfg_ee_present), .cfg_ee_spd(cfg_ee_spd), .cfg_ee_aspd(cfg_ee_aspd),
  .mac_full_duplex(mac_full_duplex), .mac_speed(mac_speed), .mac_in_reset(mac_in_reset)
);
